/* core/prog_model_pkg.sv */
// package of constants and types for the programming-model register file
// assumes one core clock and a synchronous, active-high reset
package prog_model_pkg;

    // debug command codes, read of a register then write of it; the config register has a write code only
    localparam logic [7:0] DBG_RD_DATA = 8'h60;
    localparam logic [7:0] DBG_WR_DATA = 8'h40;
    localparam logic [7:0] DBG_RD_ADDR = 8'h68;
    localparam logic [7:0] DBG_WR_ADDR = 8'h48;
    localparam logic [7:0] DBG_RD_ASP = 8'h6F;
    localparam logic [7:0] DBG_WR_ASP = 8'h4F;
    localparam logic [7:0] DBG_RD_FLAGS = 8'hEE;
    localparam logic [7:0] DBG_WR_FLAGS = 8'hCE;
    localparam logic [7:0] DBG_RD_IPTR = 8'hEF;
    localparam logic [7:0] DBG_WR_IPTR = 8'hCF;
    localparam logic [7:0] DBG_RD_ISP = 8'hE0;
    localparam logic [7:0] DBG_WR_ISP = 8'hC0;
    localparam logic [7:0] DBG_RD_VBASE = 8'hE1;
    localparam logic [7:0] DBG_WR_VBASE = 8'hC1;
    localparam logic [7:0] DBG_WR_CFG = 8'hC2;

    // control register selectors of the move-to-control instruction
    localparam logic [11:0] SEL_VBASE = 12'h801;
    localparam logic [11:0] SEL_CFG = 12'h802;

    // reset vector addresses
    localparam logic [31:0] RST_SSP_ADDR = 32'h0000_0000;
    localparam logic [31:0] RST_IPTR_ADDR = 32'h0000_0004;

    // status word layout and reset value of its upper byte
    localparam int SR_SUPER_BIT = 13;
    localparam logic [7:0] SR_RESET_HI = 8'h27;
    localparam int FLAG_X = 4;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;
    localparam logic [7:0] FLAG_MASK = 8'h1F;

    // implemented bits of the vector base
    localparam logic [31:0] VBASE_MASK = 32'h00F0_0000;

    // register index 15 on the execution side is the active stack pointer
    localparam logic [3:0] IDX_ASP = 4'hF;

    typedef enum logic [1:0] {SZ_BIT, SZ_BYTE, SZ_WORD, SZ_LONG} opsize_t;
    typedef enum logic [1:0] {ST_FETCH_SSP, ST_FETCH_IPTR, ST_RUN} phase_t;

endpackage

/* core/prog_model_regs.sv */
// programming-model register file of a small 32-bit core
// assumes a same-clock execution unit, a same-clock decoded debug command
// stream and a longword memory read port used during reset processing

module prog_model_regs (
    input wire logic clk,
    input wire logic rst,
    // hardware configuration captured into data regs 0 and 1
    input wire logic [31:0] hw_cfg0,
    input wire logic [31:0] hw_cfg1,
    // reset vector fetch port
    output logic fetch_req,
    output logic [31:0] fetch_addr,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_data,
    // execution register write
    input wire logic exe_wr_en,
    input wire logic [3:0] exe_wr_sel,
    input wire prog_model_pkg::opsize_t exe_wr_size,
    input wire logic [31:0] exe_wr_data,
    // execution register read, answered one cycle later
    input wire logic [3:0] exe_rd_sel,
    output logic [31:0] exe_rd_data,
    // user stack pointer moves
    input wire logic exe_usp_wr,
    input wire logic exe_usp_rd,
    // stack pointer and instruction pointer updates
    input wire logic exe_sp_wr,
    input wire logic [31:0] exe_sp_data,
    input wire logic exe_iptr_wr,
    input wire logic [31:0] exe_iptr_data,
    // status word write
    input wire logic exe_sr_wr,
    input wire logic [15:0] exe_sr_data,
    // move-to-control
    input wire logic exe_ctl_wr,
    input wire logic [11:0] exe_ctl_sel,
    input wire logic [31:0] exe_ctl_data,
    // flag update from an operation result
    input wire logic flag_en,
    input wire logic flag_arith,
    input wire prog_model_pkg::opsize_t flag_size,
    input wire logic [31:0] flag_result,
    input wire logic flag_carry,
    input wire logic flag_overflow,
    input wire logic flag_x_set,
    input wire logic flag_x_val,
    // decoded debug commands
    input wire logic dbg_valid,
    input wire logic [7:0] dbg_cmd,
    input wire logic [31:0] dbg_wr_data,
    output logic dbg_ack,
    output logic dbg_err,
    output logic [31:0] dbg_rd_data,
    // state seen by the rest of the core
    output logic [15:0] status_word,
    output logic [31:0] instr_ptr,
    output logic [31:0] vector_base,
    output logic [31:0] core_cfg,
    output logic priv_fault,
    output logic reset_done
);

    typedef struct packed {
        logic [7:0][31:0] data_regs;
        logic [6:0][31:0] address_regs;
        logic [31:0] active_stack_pointer;
        logic [31:0] inactive_stack_pointer;
        logic [31:0] instruction_pointer;
        logic [31:0] vector_table_base;
        logic [31:0] core_feature_config;
        logic [15:0] processor_status_word;
        prog_model_pkg::phase_t phase;
        logic fetch_req;
        logic [31:0] fetch_addr;
        logic [31:0] exe_rd_data;
        logic dbg_ack;
        logic dbg_err;
        logic [31:0] dbg_rd_data;
        logic priv_fault;
        logic reset_done;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    logic super_mode;
    logic [31:0] ext_word;
    logic [31:0] merged;
    logic res_msb;
    logic res_zero;
    logic [2:0] dbg_lo;

    // current privilege taken from the status word
    assign super_mode = state_r.processor_status_word[prog_model_pkg::SR_SUPER_BIT];
    assign dbg_lo = dbg_cmd[2:0];

    // sign-extended word for address register writes
    assign ext_word = {{16{exe_wr_data[15]}}, exe_wr_data[15:0]};

    // data register merge by operand size
    always_comb
    begin
        merged = state_r.data_regs[exe_wr_sel[2:0]];
        unique case (exe_wr_size)
            prog_model_pkg::SZ_BIT: merged[exe_wr_data[4:0]] = exe_wr_data[5];
            prog_model_pkg::SZ_BYTE: merged[7:0] = exe_wr_data[7:0];
            prog_model_pkg::SZ_WORD: merged[15:0] = exe_wr_data[15:0];
            prog_model_pkg::SZ_LONG: merged = exe_wr_data;
        endcase
    end

    // result msb and zero test by operand size
    always_comb
    begin
        res_msb = flag_result[31];
        res_zero = (flag_result == 32'h0000_0000);
        unique case (flag_size)
            prog_model_pkg::SZ_BIT, prog_model_pkg::SZ_BYTE:
            begin
                res_msb = flag_result[7];
                res_zero = (flag_result[7:0] == 8'h00);
            end
            prog_model_pkg::SZ_WORD:
            begin
                res_msb = flag_result[15];
                res_zero = (flag_result[15:0] == 16'h0000);
            end
            prog_model_pkg::SZ_LONG:
            begin
                res_msb = flag_result[31];
                res_zero = (flag_result == 32'h0000_0000);
            end
        endcase
    end

    // next-state logic for the whole register file
    always_comb
    begin
        logic [15:0] sr_new;
        logic [31:0] tmp;
        sr_new = 16'h0000;
        tmp = 32'h0000_0000;
        state_nxt = state_r;
        state_nxt.dbg_ack = 1'b0;
        state_nxt.dbg_err = 1'b0;
        state_nxt.priv_fault = 1'b0;

        // registered read port; index 15 is always the active pointer
        if (exe_rd_sel[3])
        begin
            if (exe_rd_sel == prog_model_pkg::IDX_ASP)
                state_nxt.exe_rd_data = state_r.active_stack_pointer;
            else
                state_nxt.exe_rd_data = state_r.address_regs[exe_rd_sel[2:0]];
        end
        else
            state_nxt.exe_rd_data = state_r.data_regs[exe_rd_sel[2:0]];

        // user stack pointer read, a supervisor-only move
        if (exe_usp_rd)
        begin
            if (super_mode)
                state_nxt.exe_rd_data = state_r.inactive_stack_pointer;
            else
                state_nxt.priv_fault = 1'b1;
        end

        // reset vector fetch sequence
        unique case (state_r.phase)
            prog_model_pkg::ST_FETCH_SSP:
                if (fetch_valid)
                begin
                    state_nxt.active_stack_pointer = fetch_data;
                    state_nxt.phase = prog_model_pkg::ST_FETCH_IPTR;
                    state_nxt.fetch_addr = prog_model_pkg::RST_IPTR_ADDR;
                end
            prog_model_pkg::ST_FETCH_IPTR:
                if (fetch_valid)
                begin
                    state_nxt.instruction_pointer = fetch_data;
                    state_nxt.phase = prog_model_pkg::ST_RUN;
                    state_nxt.fetch_req = 1'b0;
                    state_nxt.reset_done = 1'b1;
                end
            prog_model_pkg::ST_RUN:
            begin
            end
        endcase

        // execution writes, allowed once reset processing is over
        if (state_r.phase == prog_model_pkg::ST_RUN)
        begin
            if (exe_wr_en)
            begin
                if (!exe_wr_sel[3])
                    state_nxt.data_regs[exe_wr_sel[2:0]] = merged;
                else
                begin
                    // address regs: word writes sign-extend, narrower sizes refused
                    tmp = (exe_wr_size == prog_model_pkg::SZ_LONG) ? exe_wr_data : ext_word;
                    if (exe_wr_size == prog_model_pkg::SZ_LONG
                        || exe_wr_size == prog_model_pkg::SZ_WORD)
                    begin
                        if (exe_wr_sel == prog_model_pkg::IDX_ASP)
                            state_nxt.active_stack_pointer = tmp;
                        else
                            state_nxt.address_regs[exe_wr_sel[2:0]] = tmp;
                    end
                end
            end
            if (exe_sp_wr)
                state_nxt.active_stack_pointer = exe_sp_data;
            if (exe_iptr_wr)
                state_nxt.instruction_pointer = exe_iptr_data;

            // user stack pointer write, a supervisor-only move
            if (exe_usp_wr)
            begin
                if (super_mode)
                    state_nxt.inactive_stack_pointer = exe_wr_data;
                else
                    state_nxt.priv_fault = 1'b1;
            end

            // operation flags
            if (flag_en)
            begin
                state_nxt.processor_status_word[prog_model_pkg::FLAG_N] = res_msb;
                state_nxt.processor_status_word[prog_model_pkg::FLAG_Z] = res_zero;
                state_nxt.processor_status_word[prog_model_pkg::FLAG_V] =
                    flag_arith & flag_overflow;
                state_nxt.processor_status_word[prog_model_pkg::FLAG_C] =
                    flag_arith & flag_carry;
                if (flag_arith)
                    state_nxt.processor_status_word[prog_model_pkg::FLAG_X] = flag_carry;
                else if (flag_x_set)
                    state_nxt.processor_status_word[prog_model_pkg::FLAG_X] = flag_x_val;
            end

            // status word writes: user mode reaches only the flag byte
            if (exe_sr_wr)
            begin
                if (super_mode)
                begin
                    sr_new = exe_sr_data;
                    sr_new[7:0] = exe_sr_data[7:0] & prog_model_pkg::FLAG_MASK;
                    state_nxt.processor_status_word = sr_new;
                end
                else
                    state_nxt.processor_status_word[7:0] =
                        exe_sr_data[7:0] & prog_model_pkg::FLAG_MASK;
            end

            // move-to-control, supervisor only
            if (exe_ctl_wr)
            begin
                if (!super_mode)
                    state_nxt.priv_fault = 1'b1;
                else if (exe_ctl_sel == prog_model_pkg::SEL_VBASE)
                    state_nxt.vector_table_base =
                        exe_ctl_data & prog_model_pkg::VBASE_MASK;
                else if (exe_ctl_sel == prog_model_pkg::SEL_CFG)
                    state_nxt.core_feature_config = exe_ctl_data;
                else
                    state_nxt.priv_fault = 1'b1;
            end
        end

        // debug commands; the debug host has full privilege
        if (dbg_valid)
        begin
            state_nxt.dbg_ack = 1'b1;
            if (dbg_cmd[7:3] == prog_model_pkg::DBG_RD_DATA[7:3])
                state_nxt.dbg_rd_data = state_r.data_regs[dbg_lo];
            else if (dbg_cmd[7:3] == prog_model_pkg::DBG_WR_DATA[7:3])
                state_nxt.data_regs[dbg_lo] = dbg_wr_data;
            else if (dbg_cmd == prog_model_pkg::DBG_RD_ASP)
                state_nxt.dbg_rd_data = state_r.active_stack_pointer;
            else if (dbg_cmd == prog_model_pkg::DBG_WR_ASP)
                state_nxt.active_stack_pointer = dbg_wr_data;
            else if (dbg_cmd[7:3] == prog_model_pkg::DBG_RD_ADDR[7:3])
                state_nxt.dbg_rd_data = state_r.address_regs[dbg_lo];
            else if (dbg_cmd[7:3] == prog_model_pkg::DBG_WR_ADDR[7:3])
                state_nxt.address_regs[dbg_lo] = dbg_wr_data;
            else
            begin
                unique case (dbg_cmd)
                    prog_model_pkg::DBG_RD_FLAGS:
                        state_nxt.dbg_rd_data = {24'h000000,
                            state_r.processor_status_word[7:0]};
                    prog_model_pkg::DBG_WR_FLAGS:
                        state_nxt.processor_status_word[7:0] =
                            dbg_wr_data[7:0] & prog_model_pkg::FLAG_MASK;
                    prog_model_pkg::DBG_RD_IPTR:
                        state_nxt.dbg_rd_data = state_r.instruction_pointer;
                    prog_model_pkg::DBG_WR_IPTR:
                        state_nxt.instruction_pointer = dbg_wr_data;
                    prog_model_pkg::DBG_RD_ISP:
                        state_nxt.dbg_rd_data = state_r.inactive_stack_pointer;
                    prog_model_pkg::DBG_WR_ISP:
                        state_nxt.inactive_stack_pointer = dbg_wr_data;
                    prog_model_pkg::DBG_RD_VBASE:
                        state_nxt.dbg_rd_data = state_r.vector_table_base;
                    prog_model_pkg::DBG_WR_VBASE:
                        state_nxt.vector_table_base =
                            dbg_wr_data & prog_model_pkg::VBASE_MASK;
                    prog_model_pkg::DBG_WR_CFG:
                        state_nxt.core_feature_config = dbg_wr_data;
                    default:
                        state_nxt.dbg_err = 1'b1; // unknown code or config read
                endcase
            end
        end

        // a change of the supervisor bit outside reset swaps the two physical pointers
        if (state_nxt.processor_status_word[prog_model_pkg::SR_SUPER_BIT] != super_mode)
        begin
            state_nxt.active_stack_pointer = state_r.inactive_stack_pointer;
            state_nxt.inactive_stack_pointer = state_r.active_stack_pointer;
        end

        // synchronous reset: control state plus data regs 0 and 1 from hw_cfg0/hw_cfg1, other general regs and both pointers keep contents
        if (rst)
        begin
            state_nxt.data_regs[0] = hw_cfg0;
            state_nxt.data_regs[1] = hw_cfg1;
            state_nxt.active_stack_pointer = state_r.active_stack_pointer;
            state_nxt.inactive_stack_pointer = state_r.inactive_stack_pointer;
            state_nxt.processor_status_word = {prog_model_pkg::SR_RESET_HI,
                state_r.processor_status_word[7:0]}; // flags kept
            state_nxt.vector_table_base = 32'h0000_0000;
            state_nxt.core_feature_config = 32'h0000_0000;
            state_nxt.phase = prog_model_pkg::ST_FETCH_SSP;
            state_nxt.fetch_req = 1'b1;
            state_nxt.fetch_addr = prog_model_pkg::RST_SSP_ADDR;
            state_nxt.exe_rd_data = 32'h0000_0000;
            state_nxt.dbg_ack = 1'b0;
            state_nxt.dbg_err = 1'b0;
            state_nxt.dbg_rd_data = 32'h0000_0000;
            state_nxt.priv_fault = 1'b0;
            state_nxt.reset_done = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge clk)
    begin
        state_r <= state_nxt;
    end

    // outputs straight from the state register
    assign fetch_req = state_r.fetch_req;
    assign fetch_addr = state_r.fetch_addr;
    assign exe_rd_data = state_r.exe_rd_data;
    assign dbg_ack = state_r.dbg_ack;
    assign dbg_err = state_r.dbg_err;
    assign dbg_rd_data = state_r.dbg_rd_data;
    assign status_word = state_r.processor_status_word; // host maps pointers from it
    assign instr_ptr = state_r.instruction_pointer;
    assign vector_base = state_r.vector_table_base;
    assign core_cfg = state_r.core_feature_config;
    assign priv_fault = state_r.priv_fault;
    assign reset_done = state_r.reset_done; // set with the move to run phase

endmodule

/* tb/prog_model_regs_properties.sv */
// port checker for the programming-model register file
// assumes binding onto prog_model_regs, one clock and a synchronous reset
module prog_model_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_data,
    input wire logic exe_ctl_wr,
    input wire logic [11:0] exe_ctl_sel,
    input wire logic [31:0] exe_ctl_data,
    input wire logic dbg_valid,
    input wire logic [7:0] dbg_cmd,
    input wire logic dbg_ack,
    input wire logic dbg_err,
    input wire logic [31:0] dbg_rd_data,
    input wire logic [15:0] status_word,
    input wire logic [31:0] instr_ptr,
    input wire logic [31:0] vector_base,
    input wire logic priv_fault,
    input wire logic reset_done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // debug port answers exactly one cycle after each command
    ack_timing_a: assert property (dbg_valid |=> dbg_ack)
        else $error("debug command not acknowledged");
    ack_spurious_a: assert property (!dbg_valid |=> !dbg_ack)
        else $error("acknowledge without command");
    err_with_ack_a: assert property (dbg_err |-> dbg_ack)
        else $error("error without acknowledge");
    cfg_read_a: assert property (dbg_valid && dbg_cmd == 8'hE2 |=> dbg_err)
        else $error("configuration read not refused");
    flag_read_a: assert property (dbg_valid && dbg_cmd == 8'hEE
        |=> dbg_rd_data[31:5] == 27'h0)
        else $error("flag byte read shows reserved bits");
    // reset vector fetch order and landing of the instruction pointer
    fetch_order_a: assert property (fetch_req && fetch_valid && fetch_addr == 32'h0
        |=> fetch_req && fetch_addr == 32'h4)
        else $error("second vector fetch not at address four");
    vector_ip_a: assert property (fetch_req && fetch_valid && fetch_addr == 32'h4
        |=> instr_ptr == $past(fetch_data) && reset_done && !fetch_req)
        else $error("instruction pointer not loaded from vector");
    vbase_mask_a: assert property (exe_ctl_wr && exe_ctl_sel == 12'h801
        && status_word[13] && reset_done && !dbg_valid
        |=> vector_base == ($past(exe_ctl_data) & 32'h00F0_0000))
        else $error("vector base not written by control move");
    user_ctl_a: assert property (exe_ctl_wr && reset_done && !status_word[13]
        |=> priv_fault)
        else $error("control write in user mode not refused");
endmodule

bind prog_model_regs prog_model_checker u_prog_model_checker (.clk, .rst, .fetch_req,
    .fetch_addr, .fetch_valid, .fetch_data, .exe_ctl_wr, .exe_ctl_sel, .exe_ctl_data,
    .dbg_valid, .dbg_cmd, .dbg_ack, .dbg_err, .dbg_rd_data, .status_word, .instr_ptr,
    .vector_base, .priv_fault, .reset_done);

/* tb/vec_mem.sv */
// reset vector memory model answering the longword fetch port
// assumes the fetch port contract: one valid pulse per longword, lag set by bench
module vec_mem #(
    parameter logic [31:0] SSP_VAL = 32'h0000_2000,
    parameter logic [31:0] IPTR_VAL = 32'h0000_0410
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic [3:0] lag,
    output logic fetch_valid,
    output logic [31:0] fetch_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    // wait lag cycles, answer once, then show a changing pattern
    always_ff @(posedge clk)
    begin
        fetch_valid <= 1'b0;
        fetch_data <= ~fetch_data;
        if (rst)
        begin
            cnt_r <= 4'h0;
            fetch_data <= 32'hA5A5_A5A5;
        end
        else if (!fetch_req || fetch_valid)
            cnt_r <= 4'h0;
        else if (cnt_r >= lag)
        begin
            cnt_r <= 4'h0;
            fetch_valid <= 1'b1;
            fetch_data <= (fetch_addr == 32'h0) ? SSP_VAL : IPTR_VAL;
        end
        else
            cnt_r <= cnt_r + 4'h1;
    end
endmodule

/* tb/tb.sv */
// self-checking bench for the programming-model register file
// assumes the design, its checker and the vector memory model compiled first
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, fetch_req, fetch_valid, exe_wr_en, exe_usp_wr, exe_usp_rd, exe_sp_wr;
    logic exe_iptr_wr, exe_sr_wr, exe_ctl_wr, flag_en, flag_arith, flag_carry, flag_overflow;
    logic flag_x_set, flag_x_val, dbg_valid, dbg_ack, dbg_err, priv_fault, reset_done;
    logic [31:0] hw_cfg0, hw_cfg1, fetch_addr, fetch_data, exe_wr_data, exe_rd_data;
    logic [31:0] exe_sp_data, exe_iptr_data, exe_ctl_data, flag_result, dbg_wr_data;
    logic [31:0] dbg_rd_data, instr_ptr, vector_base, core_cfg;
    logic [15:0] exe_sr_data, status_word;
    logic [11:0] exe_ctl_sel;
    logic [7:0] dbg_cmd;
    logic [3:0] exe_wr_sel, exe_rd_sel, lag;
    prog_model_pkg::opsize_t exe_wr_size, flag_size;
    int n_fail, checks_done;

    prog_model_regs u_prog_model_regs (.clk, .rst, .hw_cfg0, .hw_cfg1, .fetch_req,
        .fetch_addr, .fetch_valid, .fetch_data, .exe_wr_en, .exe_wr_sel, .exe_wr_size,
        .exe_wr_data, .exe_rd_sel, .exe_rd_data, .exe_usp_wr, .exe_usp_rd, .exe_sp_wr,
        .exe_sp_data, .exe_iptr_wr, .exe_iptr_data, .exe_sr_wr, .exe_sr_data, .exe_ctl_wr,
        .exe_ctl_sel, .exe_ctl_data, .flag_en, .flag_arith, .flag_size, .flag_result,
        .flag_carry, .flag_overflow, .flag_x_set, .flag_x_val, .dbg_valid, .dbg_cmd,
        .dbg_wr_data, .dbg_ack, .dbg_err, .dbg_rd_data, .status_word, .instr_ptr,
        .vector_base, .core_cfg, .priv_fault, .reset_done);
    vec_mem u_vec_mem (.clk, .rst, .fetch_req, .fetch_addr, .lag, .fetch_valid, .fetch_data);

    // free-running core clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one debug command, acknowledge judged in the following cycle
    task automatic dbg(input logic [7:0] cmd, input logic [31:0] wd, input logic err);
        @(negedge clk);
        dbg_valid = 1'b1;
        dbg_cmd = cmd;
        dbg_wr_data = wd;
        @(negedge clk);
        dbg_valid = 1'b0;
        chk({30'h0, dbg_ack, dbg_err}, {30'h0, 1'b1, err});
    endtask

    // one execution strobe: 0 flags, 1 reg write, 2 control, 3 status, 4/5 user sp write/read
    task automatic ex(input int k, input logic [31:0] d);
        @(negedge clk);
        exe_wr_data = d;
        exe_ctl_data = d;
        exe_sr_data = d[15:0];
        {exe_usp_rd, exe_usp_wr, exe_sr_wr, exe_ctl_wr, exe_wr_en, flag_en} = 6'(6'b1 << k);
        @(negedge clk);
        {exe_usp_rd, exe_usp_wr, exe_sr_wr, exe_ctl_wr, exe_wr_en, flag_en} = 6'h0;
    endtask

    task automatic fl(input logic a, input prog_model_pkg::opsize_t s, input logic [31:0] r,
        input logic [3:0] cvxx, input logic [4:0] e);
        flag_arith = a;
        flag_size = s;
        flag_result = r;
        {flag_carry, flag_overflow, flag_x_set, flag_x_val} = cvxx;
        ex(0, 32'h0);
        chk({27'h0, status_word[4:0]}, {27'h0, e});
    endtask

    task automatic t_reset(input logic [3:0] l);
        lag = l;
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk({24'h0, status_word[15:8]}, 32'h27);
        for (int i = 0; i < 40 && reset_done !== 1'b1; i++)
            @(negedge clk);
        chk(instr_ptr, 32'h0000_0410);
        dbg(8'h6F, 32'h0, 1'b0);
        chk(dbg_rd_data, 32'h0000_2000);
        dbg(8'h61, 32'h0, 1'b0);
        chk(dbg_rd_data, hw_cfg1);
        $display("reset test done");
    endtask

    task automatic t_codes;
        logic [7:0] wc [0:3] = '{8'hCE, 8'hCF, 8'hC0, 8'hC1};
        logic [31:0] ev [0:3] = '{32'h1F, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h00F0_0000};
        for (int n = 0; n < 16; n++)
        begin
            dbg(8'h40 + 8'(n), 32'h1234_5600 + 32'(n), 1'b0);
            dbg(8'h60 + 8'(n), 32'h0, 1'b0);
            chk(dbg_rd_data, 32'h1234_5600 + 32'(n));
        end
        for (int i = 0; i < 4; i++)
        begin
            dbg(wc[i], 32'hFFFF_FFFF, 1'b0);
            dbg(wc[i] + 8'h20, 32'h0, 1'b0);
            chk(dbg_rd_data, ev[i]);
        end
        dbg(8'hC2, 32'hA5A5_0000, 1'b0);
        dbg(8'hE2, 32'h0, 1'b1);
        chk(core_cfg, 32'hA5A5_0000);
        dbg(8'h00, 32'h0, 1'b1);
        $display("code test done");
    endtask

    task automatic t_exec;
        exe_ctl_sel = 12'h801;
        ex(2, 32'hA5A5_A5A5);
        chk(vector_base, 32'h00A0_0000);
        exe_wr_sel = 4'h2;
        exe_wr_size = prog_model_pkg::SZ_BYTE;
        ex(1, 32'h0000_00AA);
        exe_wr_size = prog_model_pkg::SZ_BIT;
        ex(1, 32'h0000_0028);
        exe_wr_sel = 4'h8;
        exe_wr_size = prog_model_pkg::SZ_WORD;
        ex(1, 32'h0000_8001);
        exe_wr_size = prog_model_pkg::SZ_BYTE;
        ex(1, 32'h0000_0055);
        dbg(8'h62, 32'h0, 1'b0);
        chk(dbg_rd_data, 32'h1234_57AA);
        dbg(8'h68, 32'h0, 1'b0);
        chk(dbg_rd_data, 32'hFFFF_8001);
        exe_wr_sel = 4'hF;
        exe_wr_size = prog_model_pkg::SZ_LONG;
        ex(1, 32'h0000_3000);
        ex(4, 32'h0000_4000);
        chk(exe_rd_data, 32'h0000_3000);
        ex(5, 32'h0);
        chk(exe_rd_data, 32'h0000_4000);
        fl(1'b1, prog_model_pkg::SZ_BYTE, 32'h80, 4'b1000, 5'b11001);
        fl(1'b1, prog_model_pkg::SZ_LONG, 32'h0, 4'b0000, 5'b00100);
        fl(1'b1, prog_model_pkg::SZ_WORD, 32'hFFFF_7FFF, 4'b0100, 5'b00010);
        fl(1'b0, prog_model_pkg::SZ_LONG, 32'h8000_0000, 4'b1111, 5'b11000);
        fl(1'b0, prog_model_pkg::SZ_BYTE, 32'h100, 4'b0000, 5'b10100);
        ex(3, 32'h0000_0000);
        chk({31'h0, status_word[13]}, 32'h0);
        dbg(8'hE0, 32'h0, 1'b0);
        chk(dbg_rd_data, 32'h0000_3000);
        chk(exe_rd_data, 32'h0000_4000);
        ex(2, 32'h0);
        chk({31'h0, priv_fault}, 32'h1);
        ex(4, 32'h0);
        chk({31'h0, priv_fault}, 32'h1);
        ex(3, 32'h0000_2000);
        chk({31'h0, status_word[13]}, 32'h0);
        $display("execution test done");
    endtask

    // warm reset keeps the general registers that reset does not load
    task automatic t_warm;
        t_reset(4'h0);
        dbg(8'h63, 32'h0, 1'b0);
        chk(dbg_rd_data, 32'h1234_5603);
        $display("warm reset test done");
    endtask

    // main sequence: reset slow, codes, execution, second reset prompt
    initial
    begin
        {exe_wr_en, exe_usp_wr, exe_usp_rd, exe_sp_wr, exe_iptr_wr, exe_sr_wr} = 6'h0;
        {exe_ctl_wr, flag_en, flag_arith, flag_carry, flag_overflow} = 5'h0;
        {flag_x_set, flag_x_val, dbg_valid, dbg_cmd, exe_ctl_sel, exe_wr_sel} = 27'h0;
        {exe_wr_data, exe_sp_data, exe_iptr_data, exe_ctl_data, flag_result} = 160'h0;
        {dbg_wr_data, exe_sr_data, lag, exe_rd_sel} = {32'h0, 16'h0, 4'h3, 4'hF};
        {hw_cfg0, hw_cfg1} = {32'h0C0F_0001, 32'h0C0F_0002};
        exe_wr_size = prog_model_pkg::SZ_LONG;
        flag_size = prog_model_pkg::SZ_LONG;
        rst = 1'b1;
        t_reset(4'h3);
        t_codes();
        t_exec();
        t_warm();
        end_of_test();
    end

    // watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
